// File: test_utcs_top.sv
`timescale 1ns/1ps
`include "utcs_cfg.svh"
module test_utcs_top;
	import utcs_pkg::*;
	logic mclk_i, rst_b_i, cyc, stb, we, iack, full, hold, cts_b, rxd, txd, irq_b;
	logic [7:0] adr, rx_byte, rx_cnt, vec;
	logic [31:0] dat, rdat, r;
	logic ack, vec_valid, autovec, dma_req, cap_en, rts_b, rxs, rx_stb, rx_bit, ext;
	logic [1:0] dma_chan;
	int miscompares = 0;
	int comparisons = 0;
	utcs_top #(.INST(0)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd), .cts_b_i(cts_b),
		.ext_timer_clock_in_i(ext), .rx_fifo_full_flag_i(full), .rx_start_i(rxs),
		.iack_i(iack), .txd_o(txd), .rts_b_o(rts_b), .irq_b_o(irq_b), .vec_o(vec),
		.vec_valid_o(vec_valid), .autovec_o(autovec), .dma_req_o(dma_req),
		.dma_chan_o(dma_chan), .timer_cap_en_o(cap_en), .rx_stb_o(rx_stb),
		.rx_bit_o(rx_bit));
	utcs_remote #(.BIT(64)) peer (.mclk_i(mclk_i), .txd_i(txd), .hold_i(hold),
		.cts_b_o(cts_b), .rxd_o(rxd), .byte_o(rx_byte), .cnt_o(rx_cnt));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do begin
			@(posedge mclk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			miscompares++;
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk_i);
	endtask : wb
	task wait_rx(input logic [7:0] n);
		int k;
		k = 0;
		while (rx_cnt !== n && k < 3000) begin
			@(posedge mclk_i);
			k++;
		end
		if (rx_cnt !== n) begin
			miscompares++;
		end
	endtask : wait_rx
	task pulse_iack;
		@(posedge mclk_i);
		iack <= 1'b1;
		@(posedge mclk_i);
		iack <= 1'b0;
		@(posedge mclk_i);
	endtask : pulse_iack
	task final_report;
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge mclk_i);
		miscompares++;
		final_report;
	end
	initial begin
		int k;
		{cyc, stb, we, iack, full, hold, rxs, ext} = 8'h00;
		adr = 8'h00;
		dat = 32'h00000000;
		rst_b_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		wb(0, `UTCS_OFS_IVR, 8'h00);
		chk("ivr", r, 32'h0000000F);
		wb(0, `UTCS_OFS_DIVU, 8'h00);
		chk("divu", r, 32'h00000000);
		wb(0, 8'h3C, 8'h00);
		chk("unmapped", r, 32'h00000000);
		chk("txd idle", txd, 1'b1);
		chk("chan", dma_chan, 2'h2);
		chk("cap", cap_en, 1'b1);
		wb(1, `UTCS_OFS_CSEL, 8'h01);
		chk("cap ext", cap_en, 1'b0);
		wb(1, `UTCS_OFS_CSEL, 8'h00);
		full <= 1'b1;
		wb(1, `UTCS_OFS_IMR, 8'h02);
		chk("dma", dma_req, 1'b1);
		chk("irq", irq_b, 1'b0);
		wb(1, `UTCS_OFS_IMR, 8'h00);
		chk("irq masked", irq_b, 1'b1);
		wb(0, `UTCS_OFS_ISR, 8'h00);
		chk("isr full", r[1], 1'b1);
		full <= 1'b0;
		wb(1, `UTCS_OFS_DIVU, 8'h00);
		wb(1, `UTCS_OFS_DIVL, 8'h02);
		wb(1, `UTCS_OFS_MODE, 8'h03);
		wb(1, `UTCS_OFS_CMD, 8'h01);
		wb(0, `UTCS_OFS_STAT, 8'h00);
		chk("stat", r, 32'h00000003);
		wb(1, `UTCS_OFS_TXB, 8'hA5);
		wb(0, `UTCS_OFS_STAT, 8'h00);
		chk("empty low", r[1], 1'b0);
		wait_rx(8'h01);
		chk("byte", rx_byte, 8'hA5);
		repeat (200) @(posedge mclk_i);
		wb(0, `UTCS_OFS_STAT, 8'h00);
		chk("empty", r[1], 1'b1);
		chk("mark", txd, 1'b1);
		wb(1, `UTCS_OFS_AUX, 8'h01);
		wb(1, `UTCS_OFS_IMR, 8'h80);
		wb(1, `UTCS_OFS_IVR, 8'h5A);
		wb(1, `UTCS_OFS_MODE, 8'h23);
		hold <= 1'b1;
		wb(1, `UTCS_OFS_TXB, 8'h3C);
		repeat (400) @(posedge mclk_i);
		chk("cts held", rx_cnt, 8'h01);
		chk("irq cos", irq_b, 1'b0);
		pulse_iack();
		chk("vec valid", vec_valid, 1'b1);
		chk("vec", vec, 8'h5A);
		wb(1, `UTCS_OFS_AUX, 8'h03);
		pulse_iack();
		chk("autovec", autovec, 1'b1);
		chk("no vec", vec_valid, 1'b0);
		wb(1, `UTCS_OFS_ISR, 8'h80);
		chk("cos clear", irq_b, 1'b1);
		hold <= 1'b0;
		wait_rx(8'h02);
		chk("cts byte", rx_byte, 8'h3C);
		hold <= 1'b1;
		wb(1, `UTCS_OFS_CMD, 8'h08);
		repeat (200) @(posedge mclk_i);
		chk("break", txd, 1'b0);
		wb(1, `UTCS_OFS_CMD, 8'h10);
		hold <= 1'b0;
		repeat (1000) @(posedge mclk_i);
		wb(1, `UTCS_OFS_TXB, 8'h81);
		wait (txd === 1'b0);
		wb(1, `UTCS_OFS_CMD, 8'h04);
		repeat (10) @(posedge mclk_i);
		chk("reset mark", txd, 1'b1);
		wb(0, `UTCS_OFS_STAT, 8'h00);
		chk("stopped", r[0], 1'b0);
		repeat (1000) @(posedge mclk_i);
		chk("rts idle", rts_b, 1'b1);
		wb(1, `UTCS_OFS_MODE, 8'h43);
		wb(1, `UTCS_OFS_OPSET, 8'h01);
		chk("rts on", rts_b, 1'b0);
		wb(1, `UTCS_OFS_CMD, 8'h01);
		wb(1, `UTCS_OFS_TXB, 8'h55);
		wait (txd === 1'b0);
		wb(1, `UTCS_OFS_CMD, 8'h02);
		wait_rx(rx_cnt + 8'h01);
		chk("drain", rx_byte, 8'h55);
		repeat (40) @(posedge mclk_i);
		chk("rts held", rts_b, 1'b0);
		repeat (80) @(posedge mclk_i);
		chk("rts off", rts_b, 1'b1);
		wb(1, `UTCS_OFS_MODE, 8'h83);
		@(posedge mclk_i);
		chk("rts rx on", rts_b, 1'b0);
		full <= 1'b1;
		rxs <= 1'b1;
		@(posedge mclk_i);
		rxs <= 1'b0;
		@(posedge mclk_i);
		chk("rts rx off", rts_b, 1'b1);
		k = 0;
		while (rx_stb !== 1'b1 && k < 200) begin
			@(posedge mclk_i);
			k++;
		end
		chk("rx strobe", rx_stb, 1'b1);
		chk("rx bit", rx_bit, 1'b1);
		wb(1, `UTCS_OFS_CSEL, 8'h01);
		ext <= 1'b1;
		@(posedge mclk_i);
		@(posedge mclk_i);
		chk("ext rise", rx_stb, 1'b1);
		@(posedge mclk_i);
		chk("ext once", rx_stb, 1'b0);
		final_report;
	end
endmodule : test_utcs_top

// File: utcs_cfg.svh
`ifndef UTCS_CFG_SVH
`define UTCS_CFG_SVH
`define UTCS_OFS_MODE 8'h00
`define UTCS_OFS_STAT 8'h04
`define UTCS_OFS_CSEL 8'h08
`define UTCS_OFS_CMD 8'h0C
`define UTCS_OFS_TXB 8'h10
`define UTCS_OFS_ISR 8'h14
`define UTCS_OFS_IMR 8'h18
`define UTCS_OFS_IVR 8'h1C
`define UTCS_OFS_DIVU 8'h20
`define UTCS_OFS_DIVL 8'h24
`define UTCS_OFS_IPORT 8'h28
`define UTCS_OFS_OPSET 8'h2C
`define UTCS_OFS_OPCLR 8'h30
`define UTCS_OFS_AUX 8'h34
`define UTCS_CMD_EN 0
`define UTCS_CMD_DIS 1
`define UTCS_CMD_RST 2
`define UTCS_CMD_BRK_ON 3
`define UTCS_CMD_BRK_OFF 4
`define UTCS_CSEL_EXT 0
`define UTCS_CSEL_DIV16 1
`define UTCS_AUX_COS 0
`define UTCS_AUX_AUTOVEC 1
`define UTCS_AUX_LOOP 2
`define UTCS_ISR_COS 7
`define UTCS_ISR_FULL 1
`define UTCS_ISR_RDY 0
`define UTCS_IVR_RST 8'h0F
`define UTCS_DIV_RST 16'h0002
`define UTCS_PRESCALE 5'h1F
`define UTCS_EXT_DIV 4'hF
`endif

// File: utcs_div.sv
`timescale 1ns/1ps
module utcs_div #(
	parameter int W = 16
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic step_i,
	input wire logic [W-1:0] load_i,
	output logic term_o,
	output logic half_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} utcs_div_s;
	utcs_div_s q;
	utcs_div_s d;
	logic [W-1:0] half_cnt;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		half_cnt = (load_i >> 1) + W'(1);
		term_o = step_i && (q.cnt <= W'(1));
		half_o = step_i && (q.cnt == half_cnt);
		if (step_i) begin
			if (q.cnt <= W'(1)) begin
				d.cnt = load_i;
			end else begin
				d.cnt = q.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : utcs_div

// File: utcs_pkg.sv
package utcs_pkg;
	typedef enum logic [2:0] {
		UTCS_IDLE = 3'b000,
		UTCS_START = 3'b001,
		UTCS_DATA = 3'b010,
		UTCS_PAR = 3'b011,
		UTCS_STOP = 3'b100
	} utcs_tx_e;
	typedef struct packed {
		logic rts_rx;
		logic rts_tx;
		logic cts_ctl;
		logic stop2;
		logic par_odd;
		logic par_en;
		logic [1:0] len;
	} utcs_mode_s;
	typedef struct packed {
		utcs_mode_s mode;
		logic [1:0] csel;
		logic [2:0] aux;
		logic [7:0] imr;
		logic [7:0] ivr;
		logic [15:0] div;
		logic en;
		logic brk;
		logic hold_full;
		logic [7:0] hold;
		logic [7:0] sh;
		logic par;
		logic [2:0] bits;
		logic stops;
		utcs_tx_e st;
		logic txd;
		logic cos;
		logic cts_q;
		logic rts;
		logic rts_wait;
		logic ext_q;
		logic ack;
		logic [7:0] dat;
		logic vec_valid;
		logic autovec;
		logic [7:0] vec;
		logic rx_stb;
		logic rx_bit;
	} utcs_st_s;
endpackage : utcs_pkg

// File: utcs_remote.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Remote serial device: frames arriving on the line are decoded at mid-bit.
module utcs_remote #(
	parameter int BIT = 64
) (
	input wire logic mclk_i,
	input wire logic txd_i,
	input wire logic hold_i,
	output logic cts_b_o,
	output logic rxd_o,
	output logic [7:0] byte_o,
	output logic [7:0] cnt_o
);
	assign cts_b_o = hold_i;
	assign rxd_o = 1'b1;
	initial begin
		byte_o = 8'h00;
		cnt_o = 8'h00;
		forever begin
			@(negedge txd_i);
			repeat (BIT / 2) @(posedge mclk_i);
			if (txd_i === 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(posedge mclk_i);
					byte_o[i] = txd_i;
				end
				repeat (BIT) @(posedge mclk_i);
				cnt_o = cnt_o + 8'h01;
			end
		end
	end
endmodule : utcs_remote

// File: utcs_top.sv
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "utcs_cfg.svh"
module utcs_top
	import utcs_pkg::*;
#(
	parameter int INST = 0
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rxd_i,
	input wire logic cts_b_i,
	input wire logic ext_timer_clock_in_i,
	input wire logic rx_fifo_full_flag_i,
	input wire logic rx_start_i,
	input wire logic iack_i,
	output logic txd_o,
	output logic rts_b_o,
	output logic irq_b_o,
	output logic [7:0] vec_o,
	output logic vec_valid_o,
	output logic autovec_o,
	output logic dma_req_o,
	output logic [1:0] dma_chan_o,
	output logic timer_cap_en_o,
	output logic rx_stb_o,
	output logic rx_bit_o
);
	utcs_st_s q;
	utcs_st_s d;
	logic pre_term;
	logic div_term;
	logic div_half;
	logic e16_term;
	logic e16_half;
	logic ext_rise;
	logic ext_fall;
	logic fall_tick;
	logic rise_tick;
	logic hit;
	logic wr;
	logic tx_ready_flag;
	logic tx_empty_flag;
	logic cts_on;
	logic [7:0] irq_status_reg;
	logic [7:0] len_mask;
	logic [2:0] last_bit;
	logic [7:0] wdat;

	////////////////////////////////////////////////////////////////////////////
	// Clock source generation.
	utcs_div #(.W(6)) u_pre (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.step_i(1'b1),
		.load_i({1'b0, `UTCS_PRESCALE} + 6'h01),
		.term_o(pre_term),
		.half_o()
	);

	utcs_div #(.W(16)) u_baud (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.step_i(pre_term),
		.load_i(q.div),
		.term_o(div_term),
		.half_o(div_half)
	);

	utcs_div #(.W(5)) u_ext16 (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.step_i(ext_fall),
		.load_i({1'b0, `UTCS_EXT_DIV} + 5'h01),
		.term_o(e16_term),
		.half_o(e16_half)
	);

	assign ext_rise = ext_timer_clock_in_i && !q.ext_q;
	assign ext_fall = !ext_timer_clock_in_i && q.ext_q;

	always_comb begin
		if (q.csel[`UTCS_CSEL_EXT]) begin
			fall_tick = q.csel[`UTCS_CSEL_DIV16] ? e16_term : ext_fall;
			rise_tick = q.csel[`UTCS_CSEL_DIV16] ? e16_half : ext_rise;
		end else begin
			fall_tick = div_term;
			rise_tick = div_half;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags and decode.
	assign cts_on = !cts_b_i;
	assign tx_ready_flag = q.en && !q.hold_full;
	assign tx_empty_flag = q.en && !q.hold_full && (q.st == UTCS_IDLE);
	assign irq_status_reg = {q.cos, 5'h00, rx_fifo_full_flag_i, tx_ready_flag};
	assign hit = wb_cyc_i && wb_stb_i;
	assign wr = hit && q.ack && wb_we_i && wb_sel_i[0];
	assign wdat = wb_dat_i[7:0];
	assign len_mask = 8'hFF >> (2'd3 - q.mode.len);
	assign last_bit = {1'b0, q.mode.len} + 3'd4;

	////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		d = q;
		d.ext_q = ext_timer_clock_in_i;
		d.cts_q = cts_b_i;
		d.ack = hit && !q.ack;
		d.rx_stb = rise_tick;
		d.rx_bit = rise_tick ? rxd_i : q.rx_bit;
		d.vec_valid = iack_i && !irq_b_o && !q.aux[`UTCS_AUX_AUTOVEC];
		d.autovec = iack_i && !irq_b_o && q.aux[`UTCS_AUX_AUTOVEC];
		d.vec = q.ivr;
		if (hit && !q.ack) begin
			unique case (wb_adr_i)
				`UTCS_OFS_MODE: d.dat = q.mode;
				`UTCS_OFS_STAT: d.dat = {5'h00, rx_fifo_full_flag_i, tx_empty_flag, tx_ready_flag};
				`UTCS_OFS_CSEL: d.dat = {6'h00, q.csel};
				`UTCS_OFS_ISR: d.dat = irq_status_reg;
				`UTCS_OFS_IMR: d.dat = q.imr;
				`UTCS_OFS_IVR: d.dat = q.ivr;
				`UTCS_OFS_IPORT: d.dat = {7'h00, cts_b_i};
				`UTCS_OFS_AUX: d.dat = {5'h00, q.aux};
				default: d.dat = 8'h00;
			endcase
		end
		if (fall_tick) begin
			unique case (q.st)
				UTCS_IDLE: begin
					if (q.rts_wait) begin
						d.rts = 1'b0;
						d.rts_wait = 1'b0;
					end
					if (q.en && q.hold_full && !q.brk && (!q.mode.cts_ctl || cts_on)) begin
						d.sh = q.hold;
						d.hold_full = 1'b0;
						d.par = ^(q.hold & len_mask) ^ q.mode.par_odd;
						d.st = UTCS_START;
					end
				end
				UTCS_START: begin
					d.bits = 3'd0;
					d.st = UTCS_DATA;
				end
				UTCS_DATA: begin
					d.sh = q.sh >> 1;
					d.bits = q.bits + 3'd1;
					if (q.bits == last_bit) begin
						d.st = q.mode.par_en ? UTCS_PAR : UTCS_STOP;
						d.stops = 1'b0;
					end
				end
				UTCS_PAR: begin
					d.st = UTCS_STOP;
					d.stops = 1'b0;
				end
				UTCS_STOP: begin
					if (q.mode.stop2 && !q.stops) begin
						d.stops = 1'b1;
					end else begin
						d.st = UTCS_IDLE;
						if (!q.en && q.mode.rts_tx) begin
							d.rts_wait = 1'b1;
						end
					end
				end
			endcase
		end
		if (q.mode.rts_rx) begin
			if (rx_start_i && rx_fifo_full_flag_i) begin
				d.rts = 1'b0;
			end else if (!rx_fifo_full_flag_i) begin
				d.rts = 1'b1;
			end
		end
		if (wr) begin
			unique case (wb_adr_i)
				`UTCS_OFS_MODE: d.mode = wdat;
				`UTCS_OFS_CSEL: d.csel = wdat[1:0];
				`UTCS_OFS_TXB: begin
					if (tx_ready_flag) begin
						d.hold = wdat;
						d.hold_full = 1'b1;
					end
				end
				`UTCS_OFS_ISR: begin
					if (wdat[`UTCS_ISR_COS]) begin
						d.cos = 1'b0;
					end
				end
				`UTCS_OFS_IMR: d.imr = wdat;
				`UTCS_OFS_IVR: d.ivr = wdat;
				`UTCS_OFS_DIVU: d.div[15:8] = wdat;
				`UTCS_OFS_DIVL: d.div[7:0] = wdat;
				`UTCS_OFS_OPSET: begin
					if (wdat[0]) begin
						d.rts = 1'b1;
					end
				end
				`UTCS_OFS_OPCLR: begin
					if (wdat[0]) begin
						d.rts = 1'b0;
					end
				end
				`UTCS_OFS_AUX: d.aux = wdat[2:0];
				`UTCS_OFS_CMD: begin
					if (wdat[`UTCS_CMD_EN]) begin
						d.en = 1'b1;
					end
					if (wdat[`UTCS_CMD_DIS]) begin
						d.en = 1'b0;
					end
					if (wdat[`UTCS_CMD_BRK_ON]) begin
						d.brk = 1'b1;
					end
					if (wdat[`UTCS_CMD_BRK_OFF]) begin
						d.brk = 1'b0;
					end
					if (wdat[`UTCS_CMD_RST]) begin
						d.en = 1'b0;
						d.brk = 1'b0;
						d.hold_full = 1'b0;
						d.rts_wait = 1'b0;
						d.st = UTCS_IDLE;
					end
				end
				default: d.dat = q.dat;
			endcase
		end
		if (q.aux[`UTCS_AUX_COS] && (cts_b_i != q.cts_q)) begin
			d.cos = 1'b1;
		end
		if (d.brk) begin
			d.txd = 1'b0;
		end else if (q.aux[`UTCS_AUX_LOOP]) begin
			d.txd = 1'b1;
		end else begin
			unique case (d.st)
				UTCS_IDLE: d.txd = 1'b1;
				UTCS_START: d.txd = 1'b0;
				UTCS_DATA: d.txd = d.sh[0];
				UTCS_PAR: d.txd = d.par;
				UTCS_STOP: d.txd = 1'b1;
				default: d.txd = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
			q.ivr <= `UTCS_IVR_RST;
			q.div <= `UTCS_DIV_RST;
			q.txd <= 1'b1;
			q.cts_q <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign wb_ack_o = q.ack;
	assign wb_dat_o = {24'h000000, q.dat};
	assign txd_o = q.txd;
	assign rts_b_o = !q.rts;
	assign irq_b_o = !(|(irq_status_reg & q.imr));
	assign vec_o = q.vec;
	assign vec_valid_o = q.vec_valid;
	assign autovec_o = q.autovec;
	assign dma_req_o = q.imr[`UTCS_ISR_FULL] && rx_fifo_full_flag_i;
	assign dma_chan_o = (INST == 0) ? 2'h2 : 2'h3;
	assign timer_cap_en_o = !q.csel[`UTCS_CSEL_EXT];
	assign rx_stb_o = q.rx_stb;
	assign rx_bit_o = q.rx_bit;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_irq_nor_mask: assert property (
		irq_b_o == !(|({q.cos, 5'h00, rx_fifo_full_flag_i, tx_ready_flag} & q.imr)))
		else $error("Interrupt output does not match masked status.");
	a_dma_req_full: assert property (
		(q.imr[`UTCS_ISR_FULL] && rx_fifo_full_flag_i) |-> dma_req_o)
		else $error("DMA request missing while FIFO full and enabled.");
	a_idle_line_mark: assert property (
		(q.st == UTCS_IDLE && !q.brk) |-> txd_o)
		else $error("Line not at mark while idle.");
	a_break_line_low: assert property (
		q.brk |-> !txd_o)
		else $error("Line not low during break.");
	a_start_bit_low: assert property (
		(q.st == UTCS_START && !q.brk && !q.aux[`UTCS_AUX_LOOP]) |-> !txd_o)
		else $error("Start bit not low.");
	a_tx_reset_stop: assert property (
		(wr && wb_adr_i == `UTCS_OFS_CMD && wb_dat_i[`UTCS_CMD_RST])
		|=> (q.st == UTCS_IDLE && !q.en && !q.hold_full))
		else $error("Transmitter reset did not stop the transmitter.");
	a_cts_hold_idle: assert property (
		(q.st == UTCS_IDLE && q.mode.cts_ctl && cts_b_i) |=> q.st == UTCS_IDLE)
		else $error("Character started without clear-to-send.");
	a_capture_block: assert property (
		q.csel[`UTCS_CSEL_EXT] |-> !timer_cap_en_o)
		else $error("Timer capture enabled while external clock selected.");
	a_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Bus acknowledge held longer than one cycle.");
	a_data_shift_fall: assert property (
		(q.st == UTCS_DATA && !fall_tick) |=> $stable(q.sh))
		else $error("Shift register moved without a falling tick.");
endmodule : utcs_top
